// ==== phy_regs_pkg.sv ====
/*
 * Constants and carrier types for the PHY management register bank.
 * Assumes the on-chip MAC management logic presents index requests.
 */
package phy_regs_pkg;

   // Register indexes, hex as decoded by the bank
   localparam logic [4:0] IDX_CONTROL     = 5'h00;
   localparam logic [4:0] IDX_STATUS      = 5'h01;
   localparam logic [4:0] IDX_ID_HIGH     = 5'h02;
   localparam logic [4:0] IDX_ID_LOW      = 5'h03;
   localparam logic [4:0] IDX_ADVERTISE   = 5'h04;
   localparam logic [4:0] IDX_PARTNER     = 5'h05;
   localparam logic [4:0] IDX_EXPANSION   = 5'h06;
   localparam logic [4:0] IDX_MODE_CTRL   = 5'h11;
   localparam logic [4:0] IDX_SPECIAL_MOD = 5'h12;
   localparam logic [4:0] IDX_SPECIAL_IND = 5'h1B;
   localparam logic [4:0] IDX_IRQ_SOURCE  = 5'h1D;
   localparam logic [4:0] IDX_IRQ_MASK    = 5'h1E;
   localparam logic [4:0] IDX_SPECIAL_CTL = 5'h1F;

   // Control register field positions
   localparam int CTL_SOFT_RESET = 15;
   localparam int CTL_LOOPBACK   = 14;
   localparam int CTL_SPEED_100  = 13;
   localparam int CTL_AN_ENABLE  = 12;
   localparam int CTL_POWER_DOWN = 11;
   localparam int CTL_AN_RESTART = 9;
   localparam int CTL_DUPLEX     = 8;
   localparam int CTL_COL_TEST   = 7;
   // Writable control bits; reserved bits stay zero
   localparam logic [15:0] CTL_WRITE_MASK = 16'h7B80;

   // Status register field positions
   localparam int STS_AN_DONE      = 5;
   localparam int STS_REMOTE_FAULT = 4;
   localparam int STS_LINK_UP      = 2;
   localparam int STS_JABBER       = 1;
   // Fixed ability bits: 100TX FD/HD, 10T FD/HD, AN able, extended
   localparam logic [15:0] STS_FIXED = 16'h7809;

   // Identifier values, arbitrary neutral codes
   localparam logic [15:0] ID_HIGH_VALUE = 16'h1234;
   localparam logic [15:0] ID_LOW_VALUE  = 16'h5670;

   // Values after reset
   localparam logic [15:0] CTL_RESET_VALUE   = 16'h0000;
   localparam logic [15:0] STORE_RESET_VALUE = 16'h0000;
   localparam logic [15:0] ADV_RESET_VALUE   = 16'h0081;

   // Cycles after reset release before the strap level is trusted
   localparam logic [2:0] STRAP_WAIT_CYC = 3'h4;

   typedef enum logic [1:0] {
      ST_STRAP_WAIT = 2'b01,
      ST_RUN        = 2'b10
   } bank_state_t;

   typedef struct packed {
      logic [4:0]  index;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } mgmt_req_t;

   typedef struct packed {
      logic an_complete;
      logic remote_fault;
      logic link_up;
      logic jabber;
   } phy_cond_t;

endpackage : phy_regs_pkg

// ==== strap_sync.sv ====
/*
 * Three-flop synchroniser for a slow pin level with agreement filter.
 * Assumes the pin is asynchronous to clk_i and changes rarely.
 */
`timescale 1ns/1ps
module strap_sync (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic pin_i,
   output logic      level_o
);
   logic meta_q, sync_q, late_q, level_q;
   logic meta_d, sync_d, late_d, level_d;

   always_comb begin
      meta_d  = pin_i;
      sync_d  = meta_q;
      late_d  = sync_q;
      // Only the second and third stages are compared
      level_d = (sync_q == late_q) ? late_q : level_q;
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         late_q  <= 1'b0;
         level_q <= 1'b0;
      end else begin
         meta_q  <= meta_d;
         sync_q  <= sync_d;
         late_q  <= late_d;
         level_q <= level_d;
      end
   end

   assign level_o = level_q;

endmodule : strap_sync

// ==== phy_basic_control_status_regs.sv ====
/*
 * Indexed PHY management register bank: basic control and status,
 * identifiers, zero reads at indexes 5, 6 and 29, and storage at 4, 17, 18, 27, 30 and 31.
 * Assumes requests come from the MAC management logic on clk_i and
 * that condition inputs come from PHY logic on the same clock.
 */
`timescale 1ns/1ps

// How it works
// - Reached only through indexed MAC management requests.
// - Decode indexes 0-6, 17, 18, 27, 29-31.
// - Kept fields survive only control soft reset.
// - Control bit 15 starts soft reset, self-clears.
// - Bit 14 selects loopback, resets to 0.
// - Bit 13 forces 100 Mbps unless negotiating.
// - Bit 12 enables negotiation, overriding forced bits.
// - Speed and negotiation reset values from strap.
// - Bit 11 powers down; holds status 5 at 0.
// - Bit 9 restarts negotiation, then self-clears.
// - Bit 8 forces full duplex unless negotiating.
// - Status 15 reads 0, bits 14-11 read 1.
// - Status 5 shows negotiation complete, resets 0.
// - Status 4 remote fault, latched high.
// - Status 3 always reads 1.
// - Status 1 jabber, latched high, resets 0.
// - Status 0 always reads 1.
module phy_basic_control_status_regs
   import phy_regs_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire mgmt_req_t  mgmt_i,
   input  wire phy_cond_t  cond_i,
   input  wire logic       speed_strap_i,
   output logic [15:0]     rd_data_o,
   output logic            rd_valid_o,
   output logic            soft_reset_o,
   output logic            loopback_o,
   output logic            an_enable_o,
   output logic            an_restart_o,
   output logic            power_down_o,
   output logic            forced_speed_100_o,
   output logic            forced_full_duplex_o,
   output logic            col_test_o
);

   bank_state_t state_q, state_d;
   logic [2:0]  wait_q, wait_d;
   logic [15:0] ctrl_q, ctrl_d;
   logic        restart_q, restart_d;
   logic        soft_q, soft_d;
   logic        rf_q, rf_d, jab_q, jab_d, link_q, link_d, done_q, done_d;
   logic [15:0] rdata_q, rdata_d;
   logic        rvalid_q, rvalid_d;
   logic        fspeed_q, fspeed_d, fdup_q, fdup_d;
   logic [15:0] store_q [6];
   logic [15:0] store_d [6];
   logic        strap_level;
   logic        run, wr_ctrl, rd_sts, soft_go;

   strap_sync u_strap_sync (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .pin_i   (speed_strap_i),
      .level_o (strap_level)
   );

   // Storage slot for a plain read/write index, 6 when none
   function automatic logic [2:0] slot_of(input logic [4:0] idx);
      case (idx)
         IDX_ADVERTISE:   slot_of = 3'h0;
         IDX_MODE_CTRL:   slot_of = 3'h1;
         IDX_SPECIAL_MOD: slot_of = 3'h2;
         IDX_SPECIAL_IND: slot_of = 3'h3;
         IDX_IRQ_MASK:    slot_of = 3'h4;
         IDX_SPECIAL_CTL: slot_of = 3'h5;
         default:         slot_of = 3'h6;
      endcase
   endfunction : slot_of

   // Control value after any reset, speed and enable from the strap
   function automatic logic [15:0] ctrl_default(input logic strap);
      logic [15:0] v;
      v = CTL_RESET_VALUE;
      v[CTL_SPEED_100] = strap;
      v[CTL_AN_ENABLE] = strap;
      ctrl_default = v;
   endfunction : ctrl_default

   assign run     = (state_q == ST_RUN);
   assign wr_ctrl = run && mgmt_i.wr && (mgmt_i.index == IDX_CONTROL);
   assign rd_sts  = run && mgmt_i.rd && (mgmt_i.index == IDX_STATUS);
   assign soft_go = wr_ctrl && mgmt_i.wdata[CTL_SOFT_RESET];

   always_comb begin
      state_d   = state_q;
      wait_d    = wait_q;
      ctrl_d    = ctrl_q;
      restart_d = 1'b0;
      soft_d    = 1'b0;
      for (int i = 0; i < 6; i++) begin
         store_d[i] = store_q[i];
      end
      case (state_q)
         ST_STRAP_WAIT: begin
            if (wait_q == STRAP_WAIT_CYC) begin
               ctrl_d  = ctrl_default(strap_level);
               state_d = ST_RUN;
            end else begin
               wait_d = wait_q + 3'h1;
            end
         end
         ST_RUN: begin
            if (soft_go) begin
               soft_d = 1'b1;
               ctrl_d = ctrl_default(strap_level);
               for (int i = 0; i < 6; i++) begin
                  if (i != 2) begin
                     store_d[i] = (i == 0) ? ADV_RESET_VALUE
                                           : STORE_RESET_VALUE;
                  end
               end
            end else if (wr_ctrl) begin
               ctrl_d = mgmt_i.wdata & CTL_WRITE_MASK;
               restart_d = mgmt_i.wdata[CTL_AN_RESTART];
               ctrl_d[CTL_AN_RESTART] = 1'b0;
            end else if (mgmt_i.wr && slot_of(mgmt_i.index) != 3'h6) begin
               store_d[slot_of(mgmt_i.index)] = mgmt_i.wdata;
            end
         end
         default: begin
            state_d = ST_STRAP_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_q   <= ST_STRAP_WAIT;
         wait_q    <= 3'h0;
         ctrl_q    <= CTL_RESET_VALUE;
         restart_q <= 1'b0;
         soft_q    <= 1'b0;
         for (int i = 0; i < 6; i++) begin
            store_q[i] <= (i == 0) ? ADV_RESET_VALUE : STORE_RESET_VALUE;
         end
      end else begin
         state_q   <= state_d;
         wait_q    <= wait_d;
         ctrl_q    <= ctrl_d;
         restart_q <= restart_d;
         soft_q    <= soft_d;
         for (int i = 0; i < 6; i++) begin
            store_q[i] <= store_d[i];
         end
      end
   end

   // Latched status; a new event beats the read that clears it
   always_comb begin
      rf_d   = cond_i.remote_fault | (rf_q & ~rd_sts);
      jab_d  = cond_i.jabber | (jab_q & ~rd_sts);
      link_d = cond_i.link_up & (link_q | rd_sts);
      done_d = cond_i.an_complete & ~ctrl_d[CTL_POWER_DOWN];
      if (soft_go) begin
         rf_d   = 1'b0;
         jab_d  = 1'b0;
         link_d = 1'b0;
         done_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rf_q   <= 1'b0;
         jab_q  <= 1'b0;
         link_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         rf_q   <= rf_d;
         jab_q  <= jab_d;
         link_q <= link_d;
         done_q <= done_d;
      end
   end

   // Read path; unmapped indexes answer zero
   always_comb begin
      rvalid_d = run && mgmt_i.rd;
      rdata_d  = 16'h0000;
      case (mgmt_i.index)
         IDX_CONTROL: rdata_d = ctrl_q;
         IDX_STATUS: begin
            rdata_d = STS_FIXED;
            rdata_d[STS_AN_DONE] = done_q;
            rdata_d[STS_REMOTE_FAULT] = rf_q;
            rdata_d[STS_LINK_UP]      = link_q;
            rdata_d[STS_JABBER]       = jab_q;
         end
         IDX_ID_HIGH: rdata_d = ID_HIGH_VALUE;
         IDX_ID_LOW:  rdata_d = ID_LOW_VALUE;
         IDX_PARTNER, IDX_EXPANSION, IDX_IRQ_SOURCE: rdata_d = 16'h0000;
         default: begin
            if (slot_of(mgmt_i.index) != 3'h6) begin
               rdata_d = store_q[slot_of(mgmt_i.index)];
            end
         end
      endcase
      if (!rvalid_d) begin
         rdata_d = rdata_q;
      end
      fspeed_d = ctrl_d[CTL_SPEED_100] & ~ctrl_d[CTL_AN_ENABLE];
      fdup_d   = ctrl_d[CTL_DUPLEX] & ~ctrl_d[CTL_AN_ENABLE];
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
         fspeed_q <= 1'b0;
         fdup_q   <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         fspeed_q <= fspeed_d;
         fdup_q   <= fdup_d;
      end
   end

   assign rd_data_o            = rdata_q;
   assign rd_valid_o           = rvalid_q;
   assign soft_reset_o         = soft_q;
   assign loopback_o           = ctrl_q[CTL_LOOPBACK];
   assign an_enable_o          = ctrl_q[CTL_AN_ENABLE];
   assign an_restart_o         = restart_q;
   assign power_down_o         = ctrl_q[CTL_POWER_DOWN];
   assign forced_speed_100_o   = fspeed_q;
   assign forced_full_duplex_o = fdup_q;
   assign col_test_o           = ctrl_q[CTL_COL_TEST];

   a_soft_reset_go: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      soft_go |=> soft_reset_o && !loopback_o && !col_test_o
                  && !power_down_o && ctrl_q[CTL_SOFT_RESET] == 1'b0)
      else $error("soft reset did not restore control");
   a_strap_default: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      (state_q == ST_STRAP_WAIT && wait_q == STRAP_WAIT_CYC)
      |=> an_enable_o == $past(strap_level)
          && ctrl_q[CTL_SPEED_100] == $past(strap_level))
      else $error("strap level not loaded");
   a_forced_ignored: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      an_enable_o |-> !forced_speed_100_o && !forced_full_duplex_o)
      else $error("forced mode active while negotiating");
   a_restart_pulse: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      (wr_ctrl && !soft_go && mgmt_i.wdata[CTL_AN_RESTART])
      |=> an_restart_o
          ##1 (!an_restart_o
               || $past(wr_ctrl && !soft_go
                        && mgmt_i.wdata[CTL_AN_RESTART])))
      else $error("restart not a single pulse");
   a_status_fixed: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      rd_sts |=> rd_valid_o && rd_data_o[15:11] == 5'h0F
                 && rd_data_o[3] && rd_data_o[0] && rd_data_o[10:6] == 5'h00)
      else $error("status fixed bits wrong");
   a_fault_latched: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      (cond_i.remote_fault && !soft_go) ##1 rd_sts |=> rd_data_o[4])
      else $error("remote fault not latched");
   a_jabber_latched: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      (cond_i.jabber && !soft_go) ##1 rd_sts |=> rd_data_o[1])
      else $error("jabber not latched");
   a_link_latched: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      !cond_i.link_up ##1 rd_sts |=> !rd_data_o[2])
      else $error("link drop not latched low");
   a_ctrl_reserved: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      (run && mgmt_i.rd && mgmt_i.index == IDX_CONTROL)
      |=> rd_data_o[6:0] == 7'h00 && !rd_data_o[10] && !rd_data_o[15])
      else $error("reserved control bits not zero");
   a_unmapped_zero: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      (run && mgmt_i.rd && mgmt_i.index == 5'h07) |=> rd_data_o == 16'h0000)
      else $error("unmapped index did not read zero");

endmodule : phy_basic_control_status_regs

// ==== mac_mgmt_model.sv ====
/*
 * Behavioural model of the MAC management logic that reaches the PHY
 * bank by register index, one request at a time.
 * Assumes clk_i is the bank clock and the bench calls one task at once.
 */
`timescale 1ns/1ps
module mac_mgmt_model
   import phy_regs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [15:0] rd_data_i,
   input  wire logic        rd_valid_i,
   output mgmt_req_t        mgmt_o
);
   initial mgmt_o = '0;

   // Released lines show the inverse so stale values cannot pass
   task automatic release_bus();
      @(negedge clk_i);
      mgmt_o.wr    = 1'b0;
      mgmt_o.rd    = 1'b0;
      mgmt_o.index = ~mgmt_o.index;
      mgmt_o.wdata = ~mgmt_o.wdata;
   endtask : release_bus

   task automatic write_reg(input logic [4:0] idx, input logic [15:0] data);
      @(negedge clk_i);
      mgmt_o.index = idx;
      mgmt_o.wdata = data;
      mgmt_o.wr    = 1'b1;
      release_bus();
   endtask : write_reg

   task automatic read_reg(input  logic [4:0]  idx,
                           output logic [15:0] data,
                           output logic        ok);
      ok   = 1'b0;
      data = '0;
      @(negedge clk_i);
      mgmt_o.index = idx;
      mgmt_o.rd    = 1'b1;
      release_bus();
      for (int n = 0; n < 4; n++) begin
         if (!ok && rd_valid_i === 1'b1) begin
            ok   = 1'b1;
            data = rd_data_i;
         end
         @(negedge clk_i);
      end
   endtask : read_reg
endmodule : mac_mgmt_model

// ==== testbench.sv ====
/*
 * Self-checking bench for the PHY basic control and status bank.
 * Assumes the MAC model carries all register traffic; strap and
 * condition inputs are driven here at the falling edge.
 */
`timescale 1ns/1ps
`define CHECK(got, exp) check_value(16'(got), 16'(exp))
module testbench
   import phy_regs_pkg::*;
();
   logic        clk, rstn, strap, rd_valid, soft_rst, loopback, an_en;
   logic        an_rst, pdown, spd100, fdx, col, ok;
   mgmt_req_t   mgmt;
   phy_cond_t   cond;
   logic [15:0] rd_data, v, w, got;
   int          mismatches, checks_done, seed, soft_cnt, rst_cnt, n0;

   phy_basic_control_status_regs DUT (
      .clk_i(clk), .rstn_i(rstn), .mgmt_i(mgmt), .cond_i(cond),
      .speed_strap_i(strap), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .soft_reset_o(soft_rst), .loopback_o(loopback), .an_enable_o(an_en),
      .an_restart_o(an_rst), .power_down_o(pdown),
      .forced_speed_100_o(spd100), .forced_full_duplex_o(fdx),
      .col_test_o(col)
   );

   mac_mgmt_model mac (
      .clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .mgmt_o(mgmt)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pulses counted at the quiet edge, away from register updates
   always @(negedge clk) begin
      if (soft_rst === 1'b1) soft_cnt++;
      if (an_rst === 1'b1) rst_cnt++;
   end

   task automatic check_value(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check_value

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   task automatic rd(input logic [4:0] idx);
      mac.read_reg(idx, got, ok);
      if (!ok) begin
         mismatches++;
         test_done();
      end
   endtask : rd

   // Write issued inside the strap wait must be dropped
   task automatic hard_reset(input logic s);
      @(negedge clk);
      strap = s;
      rstn  = 1'b0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      mac.write_reg(IDX_ADVERTISE, 16'hFFFF);
      repeat (8) @(negedge clk);
   endtask : hard_reset

   function automatic logic [15:0] exp_status(input logic an, rf, lk, jb);
      return 16'h7809 | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
   endfunction : exp_status

   function automatic logic [15:0] exp_index(input logic [4:0]  i,
                                             input logic [15:0] d);
      case (i)
         IDX_ID_HIGH: return ID_HIGH_VALUE;
         IDX_ID_LOW:  return ID_LOW_VALUE;
         IDX_ADVERTISE, IDX_MODE_CTRL, IDX_SPECIAL_MOD, IDX_SPECIAL_IND,
         IDX_IRQ_MASK, IDX_SPECIAL_CTL: return d;
         default: return 16'h0000;
      endcase
   endfunction : exp_index

   initial begin
      rstn = 1'b0;
      strap = 1'b1;
      cond = '0;
      seed = 19486;
      mismatches = 0;
      checks_done = 0;
      soft_cnt = 0;
      rst_cnt = 0;
      hard_reset(1'b1);
      rd(IDX_ADVERTISE); `CHECK(got, 16'h0081); // early write lost
      rd(IDX_CONTROL); `CHECK(got, 16'h3000); // strap high
      `CHECK(an_en, 1'b1); // negotiation on
      cond.link_up = 1'b1;
      mac.write_reg(IDX_STATUS, 16'h0000);
      rd(IDX_STATUS); `CHECK(got, exp_status(0, 0, 0, 0)); // reset 0
      rd(IDX_STATUS); `CHECK(got, exp_status(0, 0, 1, 0)); // re-arm
      cond = '{1'b1, 1'b1, 1'b0, 1'b1};
      @(negedge clk);
      cond = '{1'b1, 1'b0, 1'b1, 1'b0};
      repeat (2) @(negedge clk);
      rd(IDX_STATUS); `CHECK(got, exp_status(1, 1, 0, 1)); // latched
      rd(IDX_STATUS); `CHECK(got, exp_status(1, 0, 1, 0)); // cleared
      // Event one cycle ahead of the read, then in the read's own cycle
      cond = '{1'b1, 1'b1, 1'b0, 1'b1};
      fork
         rd(IDX_STATUS);
         begin
            @(negedge clk);
            cond = '{1'b1, 1'b0, 1'b1, 1'b0};
         end
      join
      `CHECK(got, exp_status(1, 1, 0, 1)); // event then read
      fork
         rd(IDX_STATUS);
         begin
            @(negedge clk);
            cond = '{1'b1, 1'b1, 1'b0, 1'b1};
            @(negedge clk);
            cond = '{1'b1, 1'b0, 1'b1, 1'b0};
         end
      join
      `CHECK(got, exp_status(1, 0, 1, 0)); // read shows old value
      rd(IDX_STATUS); `CHECK(got, exp_status(1, 1, 0, 1)); // set wins
      mac.write_reg(IDX_CONTROL, 16'h0800);
      rd(IDX_STATUS); `CHECK(got, exp_status(0, 0, 1, 0)); // powered off
      mac.write_reg(IDX_CONTROL, 16'h1000);
      repeat (3) @(negedge clk);
      rd(IDX_STATUS); `CHECK(got, exp_status(1, 0, 1, 0)); // complete
      for (int i = 0; i < 24; i++) begin
         w = 16'($random(seed)) & 16'h7FFF;
         if (i < 2) w = (i == 0) ? 16'h0000 : 16'h7FFF;
         n0 = rst_cnt;
         mac.write_reg(IDX_CONTROL, w);
         repeat (2) @(negedge clk);
         `CHECK(rst_cnt - n0, w[9]); // restart pulse
         `CHECK(loopback, w[14]); // loopback
         `CHECK(spd100, w[13] & ~w[12]); // forced speed
         `CHECK(an_en, w[12]); // negotiation
         `CHECK(pdown, w[11]); // power down
         `CHECK(fdx, w[8] & ~w[12]); // forced duplex
         `CHECK(col, w[7]); // collision test
         rd(IDX_CONTROL); `CHECK(got, w & 16'h7980); // reserved zero
      end
      v = 16'($random(seed));
      mac.write_reg(IDX_SPECIAL_MOD, v);
      mac.write_reg(IDX_MODE_CTRL, ~v);
      n0 = soft_cnt;
      mac.write_reg(IDX_CONTROL, 16'h8000);
      repeat (2) @(negedge clk);
      `CHECK(soft_cnt - n0, 1); // one reset pulse
      rd(IDX_CONTROL); `CHECK(got, 16'h3000); // self clearing
      rd(IDX_SPECIAL_MOD); `CHECK(got, v); // kept store
      rd(IDX_MODE_CTRL); `CHECK(got, 16'h0000); // plain store
      for (int i = 2; i < 32; i++) begin
         w = 16'($random(seed));
         mac.write_reg(5'(i), w);
         rd(5'(i)); `CHECK(got, exp_index(5'(i), w)); // decode
      end
      hard_reset(1'b0);
      rd(IDX_SPECIAL_MOD); `CHECK(got, 16'h0000); // hard reset
      rd(IDX_CONTROL); `CHECK(got, 16'h0000); // strap low
      test_done();
   end
endmodule : testbench
